//--- verilog/ipv_pkg.sv
// constants and types shared by the interrupt priority and vector unit
package ipv_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] OFS_TEST_CTRL = 8'h15;
  localparam logic [7:0] OFS_TEST_BITS = 8'h16;
  localparam logic [7:0] OFS_PROMOTE = 8'h1F;

  // test control field positions
  localparam int unsigned CTRL_WRT_BIT = 4;
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_SEL_W = 4;

  // sources indexed by vector low byte / 2: 0..121 I-maskable, 122 X
  localparam int unsigned NUM_SRC = 123;
  localparam int unsigned NUM_I_SRC = 122;
  localparam int unsigned NUM_GROUPS = 16;
  localparam int unsigned GROUP_BITS = 8;
  localparam int unsigned PAD_SRC = NUM_GROUPS * GROUP_BITS;
  localparam logic [6:0] IDX_IRQ = 7'h79;
  localparam logic [6:0] IDX_NONMASKABLE_PIN_REQUEST = 7'h7A;

  // vector page and fixed vectors
  localparam logic [7:0] VEC_PAGE = 8'hFF;
  localparam logic [15:0] VEC_SYS_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_CLKMON_RESET = 16'hFFFC;
  localparam logic [15:0] VEC_WATCHDOG_RESET = 16'hFFFA;
  localparam logic [15:0] VEC_TRAP = 16'hFFF8;
  localparam logic [15:0] VEC_SWI = 16'hFFF6;
  localparam logic [15:0] VEC_NONMASKABLE_PIN_REQUEST = 16'hFFF4;

  // promotion select: highest legal value and reset value
  localparam logic [7:0] PROMOTE_MAX = 8'hF2;
  localparam logic [6:0] PROMOTE_RESET = 7'h79;

  // reset values
  localparam logic [7:0] TEST_BITS_RESET = 8'h00;
  localparam logic [15:0] VEC_ADDR_RESET = 16'h0000;

  // state of one test register group
  typedef struct packed {
    logic [7:0] bits;
  } ipv_group_s;

  // state of the unit
  typedef struct packed {
    logic wrt;
    logic [3:0] sel;
    logic [6:0] psel;
    logic [7:0] rdata;
    logic [15:0] last_vec;
    logic seen;
    logic [15:0] vec_addr;
    logic vec_valid;
    logic pending;
  } ipv_state_s;

endpackage : ipv_pkg

//--- verilog/ipv_test_group.sv
// one test register group: eight forced request bits
`timescale 1ns/100ps
module ipv_test_group
  import ipv_pkg::*;
#(
  parameter int unsigned GROUP = 0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] forced
);

  ipv_group_s s_reg;
  ipv_group_s s_next;
  logic [7:0] impl_mask;

  // bits past the last source stay zero, so they cannot be tested
  always_comb begin
    for (int k = 0; k < GROUP_BITS; k++) begin
      impl_mask[k] = ((GROUP * GROUP_BITS + k) < NUM_SRC);
    end
  end

  // forced bits persist until software overwrites them
  always_comb begin
    s_next = s_reg;
    if (wr_en) begin
      s_next.bits = wdata & impl_mask;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg.bits <= TEST_BITS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign forced = s_reg.bits;

endmodule : ipv_test_group

//--- verilog/ipv_unit.sv
// interrupt priority and vector unit: test registers, promotion, decoder
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module ipv_unit
  import ipv_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic SPECIAL_MODE,
  input wire logic CCR_I_MASK,
  input wire logic CCR_X_MASK,
  input wire logic [NUM_SRC-1:0] INT_REQ,
  input wire logic SYS_RESET_REQ,
  input wire logic CLKMON_RESET_REQ,
  input wire logic WATCHDOG_RESET_REQ,
  input wire logic TRAP_REQ,
  input wire logic SWI_REQ,
  input wire logic VEC_REQ,
  output logic [15:0] VEC_ADDR,
  output logic VEC_VALID,
  output logic INT_PENDING
);

  ipv_state_s s_reg;
  ipv_state_s s_next;

  logic [PAD_SRC-1:0] forced_flat;
  logic [PAD_SRC-1:0] live_pad;
  logic [NUM_SRC-1:0] eff_req;
  logic [NUM_I_SRC-1:0] i_valid;
  logic x_valid;
  logic [6:0] prom_idx;
  logic [6:0] hi_idx;
  logic [15:0] best_vec;
  logic best_found;
  logic test_wr;
  logic ctl_wr_ok;
  logic [7:0] test_rd;
  logic [6:0] grp_base;

  // one test register per group of eight sources
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : gen_grp
      ipv_test_group #(
        .GROUP(g)
      ) u_grp (
        .clk_sys(CLK_SYS),
        .rst(RST),
        .wr_en(test_wr && (s_reg.sel == 4'(g))),
        .wdata(REG_WDATA),
        .forced(forced_flat[g*GROUP_BITS +: GROUP_BITS])
      );
    end
  endgenerate

  // access qualifiers for the guarded registers
  assign test_wr = REG_WR && (REG_ADDR == OFS_TEST_BITS) && SPECIAL_MODE
    && s_reg.wrt && CCR_I_MASK;
  assign ctl_wr_ok = SPECIAL_MODE && CCR_I_MASK && CCR_X_MASK;
  assign live_pad = {{(PAD_SRC-NUM_SRC){1'b0}}, INT_REQ};
  assign grp_base = {s_reg.sel, 3'b000};

  // test read: live lines or forced bits, missing sources read zero
  always_comb begin
    if (!SPECIAL_MODE) begin
      test_rd = 8'h00;
    end else if (s_reg.wrt) begin
      test_rd = forced_flat[grp_base +: GROUP_BITS];
    end else begin
      test_rd = live_pad[grp_base +: GROUP_BITS];
    end
  end

  // real lines are cut off while test write mode is on
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      eff_req[i] = s_reg.wrt ? forced_flat[i] : INT_REQ[i];
    end
    i_valid = eff_req[NUM_I_SRC-1:0] & {NUM_I_SRC{~CCR_I_MASK}};
    x_valid = eff_req[IDX_NONMASKABLE_PIN_REQUEST] & ~CCR_X_MASK;
  end

  // promotion index; anything above the IRQ slot means IRQ
  always_comb begin
    if ({s_reg.psel, 1'b0} > PROMOTE_MAX) begin
      prom_idx = IDX_IRQ;
    end else begin
      prom_idx = s_reg.psel;
    end
  end

  // plain I priority: higher vector address wins
  always_comb begin
    hi_idx = 7'h00;
    for (int i = 0; i < NUM_I_SRC; i++) begin
      if (i_valid[i]) begin
        hi_idx = 7'(i);
      end
    end
  end

  // full exception priority chain
  always_comb begin
    best_found = 1'b1;
    if (SYS_RESET_REQ) begin
      best_vec = VEC_SYS_RESET;
    end else if (CLKMON_RESET_REQ) begin
      best_vec = VEC_CLKMON_RESET;
    end else if (WATCHDOG_RESET_REQ) begin
      best_vec = VEC_WATCHDOG_RESET;
    end else if (TRAP_REQ) begin
      best_vec = VEC_TRAP;
    end else if (SWI_REQ) begin
      best_vec = VEC_SWI;
    end else if (x_valid) begin
      best_vec = VEC_NONMASKABLE_PIN_REQUEST;
    end else if (i_valid[prom_idx]) begin
      best_vec = {VEC_PAGE, prom_idx, 1'b0};
    end else if (|i_valid) begin
      best_vec = {VEC_PAGE, hi_idx, 1'b0};
    end else begin
      best_vec = VEC_SWI;
      best_found = 1'b0;
    end
  end

  // register port, vector answer and sequence memory
  always_comb begin
    s_next = s_reg;
    s_next.rdata = 8'h00;
    s_next.vec_valid = 1'b0;
    s_next.pending = best_found;
    if (REG_WR && (REG_ADDR == OFS_TEST_CTRL)) begin
      s_next.sel = REG_WDATA[CTRL_SEL_LSB +: CTRL_SEL_W];
      if (ctl_wr_ok) begin
        s_next.wrt = REG_WDATA[CTRL_WRT_BIT];
      end
    end
    if (REG_WR && (REG_ADDR == OFS_PROMOTE) && CCR_I_MASK) begin
      s_next.psel = REG_WDATA[7:1];
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        OFS_TEST_CTRL: s_next.rdata = {3'b000, s_reg.wrt, s_reg.sel};
        OFS_TEST_BITS: s_next.rdata = test_rd;
        OFS_PROMOTE: s_next.rdata = {s_reg.psel, 1'b0};
        default: s_next.rdata = 8'h00;
      endcase
    end
    // the latest valid vector stands in for a request that dropped
    if (best_found) begin
      s_next.last_vec = best_vec;
      s_next.seen = 1'b1;
    end
    if (VEC_REQ) begin
      s_next.vec_valid = 1'b1;
      if (best_found) begin
        s_next.vec_addr = best_vec;
      end else if (s_reg.seen) begin
        s_next.vec_addr = s_reg.last_vec;
      end else begin
        s_next.vec_addr = VEC_SWI;
      end
    end
  end

  // state register; promotion resets to the IRQ slot
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s_reg.wrt <= 1'b0;
      s_reg.sel <= 4'h0;
      s_reg.psel <= PROMOTE_RESET;
      s_reg.rdata <= 8'h00;
      s_reg.last_vec <= VEC_SWI;
      s_reg.seen <= 1'b0;
      s_reg.vec_addr <= VEC_ADDR_RESET;
      s_reg.vec_valid <= 1'b0;
      s_reg.pending <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign REG_RDATA = s_reg.rdata;
  assign VEC_ADDR = s_reg.vec_addr;
  assign VEC_VALID = s_reg.vec_valid;
  assign INT_PENDING = s_reg.pending;

  // checks on register access
  a_test_read_normal: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    REG_RD && (REG_ADDR == OFS_TEST_BITS) && !SPECIAL_MODE
    |=> REG_RDATA == 8'h00)
    else $error("test bits read nonzero in normal mode");

  a_test_write_guard: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    REG_WR && (REG_ADDR == OFS_TEST_BITS)
    && !(SPECIAL_MODE && s_reg.wrt && CCR_I_MASK)
    |=> $stable(forced_flat))
    else $error("guarded test write changed forced bits");

  a_group_f_high: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    REG_RD && (REG_ADDR == OFS_TEST_BITS) && (s_reg.sel == 4'hF)
    |=> REG_RDATA[7:3] == 5'b00000)
    else $error("group F upper bits read nonzero");

  a_wrt_guard: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    REG_WR && (REG_ADDR == OFS_TEST_CTRL) && !ctl_wr_ok
    |=> $stable(s_reg.wrt))
    else $error("test write enable changed without permission");

  a_promote_guard: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    REG_WR && (REG_ADDR == OFS_PROMOTE) && !CCR_I_MASK
    |=> $stable(s_reg.psel))
    else $error("promotion changed with I mask clear");

  // checks on the vector answer
  a_vec_timing: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    VEC_REQ |=> VEC_VALID ##1 !VEC_VALID || $past(VEC_REQ))
    else $error("vector answer not one cycle after request");

  a_sys_reset_top: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    VEC_REQ && SYS_RESET_REQ |=> VEC_ADDR == VEC_SYS_RESET)
    else $error("system reset vector not supplied");

  a_trap_order: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    VEC_REQ && TRAP_REQ && !SYS_RESET_REQ && !CLKMON_RESET_REQ
    && !WATCHDOG_RESET_REQ |=> VEC_ADDR == VEC_TRAP)
    else $error("trap vector not supplied");

  a_promote_wins: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    VEC_REQ && !SYS_RESET_REQ && !CLKMON_RESET_REQ
    && !WATCHDOG_RESET_REQ && !TRAP_REQ && !SWI_REQ && !x_valid
    && i_valid[prom_idx] |=> VEC_ADDR == {VEC_PAGE, $past(prom_idx), 1'b0})
    else $error("promoted source not first among I sources");

  a_default_swi: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    VEC_REQ && !best_found && !s_reg.seen |=> VEC_ADDR == VEC_SWI)
    else $error("default software vector not supplied");

  a_last_valid: assert property (@(posedge CLK_SYS)
    disable iff (RST)
    VEC_REQ && !best_found && s_reg.seen
    |=> VEC_ADDR == $past(s_reg.last_vec))
    else $error("last valid vector not supplied");

  // main scenarios
  c_vec_pending: cover property (@(posedge CLK_SYS) disable iff (RST)
    VEC_REQ && (|i_valid));
  c_test_write: cover property (@(posedge CLK_SYS) disable iff (RST)
    test_wr);
  c_promote_used: cover property (@(posedge CLK_SYS) disable iff (RST)
    VEC_REQ && i_valid[prom_idx] && (hi_idx != prom_idx));
  c_dropped_req: cover property (@(posedge CLK_SYS) disable iff (RST)
    VEC_REQ && !best_found && s_reg.seen);

endmodule : ipv_unit

//--- bench/ipv_cpu_model.sv
// cpu side model: raises vector requests and captures the answers
`timescale 1ns/100ps
module ipv_cpu_model
  import ipv_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ask,
  input wire logic [15:0] vec_addr,
  input wire logic vec_valid,
  output logic vec_req,
  output logic [15:0] vec_seen,
  output logic late
);
  logic req_d;
  // one-cycle request; any answer off by a cycle sticks in late
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vec_req <= 1'b0;
      req_d <= 1'b0;
      vec_seen <= 16'h0000;
      late <= 1'b0;
    end else begin
      vec_req <= ask & ~vec_req;
      req_d <= vec_req;
      late <= late | (vec_valid != req_d);
      if (vec_valid) begin
        vec_seen <= vec_addr;
      end
    end
  end
endmodule : ipv_cpu_model

//--- bench/interrupt_priority_vector_unit_bench.sv
// self-checking bench for the interrupt priority and vector unit
`timescale 1ns/100ps
module interrupt_priority_vector_unit_bench
  import ipv_pkg::*;
;
  logic clk_sys, rst, wr, rd, spec, imask, xmask, ask, pend, late;
  logic sys_r, cm_r, wd_r, trap_r, swi_r, vec_req, vec_valid;
  logic [7:0] addr, wdata, rdata, prom, b;
  logic [NUM_SRC-1:0] int_req, r;
  logic [15:0] vec_addr, vec_seen, last;
  int n_fail, checks_done;

  ipv_unit u_dut (.CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .SPECIAL_MODE(spec), .CCR_I_MASK(imask), .CCR_X_MASK(xmask),
    .INT_REQ(int_req), .SYS_RESET_REQ(sys_r), .CLKMON_RESET_REQ(cm_r),
    .WATCHDOG_RESET_REQ(wd_r), .TRAP_REQ(trap_r), .SWI_REQ(swi_r),
    .VEC_REQ(vec_req), .VEC_ADDR(vec_addr), .VEC_VALID(vec_valid),
    .INT_PENDING(pend));
  ipv_cpu_model u_cpu (.clk_sys(clk_sys), .rst(rst), .ask(ask),
    .vec_addr(vec_addr), .vec_valid(vec_valid), .vec_req(vec_req),
    .vec_seen(vec_seen), .late(late));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // expected vector from the fixed priority order; last covers no request
  function automatic logic [15:0] best_vec(output bit found);
    logic [6:0] p;
    p = (prom > PROMOTE_MAX) ? IDX_IRQ : prom[7:1];
    found = 1'b1;
    if (sys_r) return VEC_SYS_RESET;
    if (cm_r) return VEC_CLKMON_RESET;
    if (wd_r) return VEC_WATCHDOG_RESET;
    if (trap_r) return VEC_TRAP;
    if (swi_r) return VEC_SWI;
    if (!xmask && int_req[IDX_NONMASKABLE_PIN_REQUEST]) return VEC_NONMASKABLE_PIN_REQUEST;
    if (!imask && int_req[p]) return {VEC_PAGE, p, 1'b0};
    for (int i = NUM_I_SRC - 1; i >= 0; i--) begin
      if (!imask && int_req[i]) return {VEC_PAGE, 7'(i), 1'b0};
    end
    found = 1'b0;
    return last;
  endfunction : best_vec

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg

  // read data is looked at only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    check({8'h00, rdata}, {8'h00, exp});
  endtask : rd_reg

  // fixed of zero means work the answer out; requests held until answered
  task automatic vec_chk(input logic [15:0] fixed);
    bit f;
    logic [15:0] e;
    @(posedge clk_sys);
    ask <= 1'b1;
    e = (fixed == 16'h0000) ? best_vec(f) : fixed;
    @(posedge clk_sys);
    ask <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check(vec_seen, e);
    if (fixed == 16'h0000) begin
      check({15'h0000, pend}, {15'h0000, f});
      if (f) last = e;
    end
  endtask : vec_chk

  task automatic stop_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // watchdog far beyond the expected few hundred cycles
  initial begin
    #300us;
    n_fail++;
    stop_test();
  end

  initial begin
    {wr, rd, ask, spec, sys_r, cm_r, wd_r, trap_r, swi_r} = '0;
    {rst, imask, xmask} = 3'b111;
    {addr, wdata} = 16'h0000;
    int_req = '0;
    prom = PROMOTE_MAX;
    last = VEC_SWI;
    n_fail = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    void'($urandom(32'he644_4886));
    rd_reg(OFS_TEST_CTRL, 8'h00);
    rd_reg(OFS_PROMOTE, PROMOTE_MAX);
    rd_reg(8'h20, 8'h00);
    vec_chk(16'h0000);
    // random requests against the promotion and priority order
    for (int k = 0; k < 40; k++) begin
      imask <= 1'b1;
      b = (k == 0) ? 8'hF5 : 8'($urandom_range(0, 255));
      wr_reg(OFS_PROMOTE, b);
      prom = {b[7:1], 1'b0};
      rd_reg(OFS_PROMOTE, prom);
      r = '0;
      r[$urandom_range(0, 122)] = 1'b1;
      r[$urandom_range(0, 122)] = 1'b1;
      if (prom <= PROMOTE_MAX && $urandom_range(0, 1)) r[prom[7:1]] = 1'b1;
      int_req <= r;
      sys_r <= ($urandom_range(0, 15) == 0);
      cm_r <= ($urandom_range(0, 15) == 0);
      wd_r <= ($urandom_range(0, 15) == 0);
      trap_r <= ($urandom_range(0, 15) == 0);
      swi_r <= ($urandom_range(0, 15) == 0);
      imask <= ($urandom_range(0, 3) == 0);
      xmask <= 1'($urandom_range(0, 1));
      vec_chk(16'h0000);
    end
    // test registers: normal, live, refused and forced
    {sys_r, cm_r, wd_r, trap_r, swi_r} <= '0;
    int_req <= 123'({4{32'h5A3C_96E1}});
    {imask, xmask} <= 2'b11;
    // back to the IRQ default, so a random promotion cannot reorder
    // the forced sources below
    wr_reg(OFS_PROMOTE, PROMOTE_MAX);
    prom = PROMOTE_MAX;
    rd_reg(OFS_TEST_BITS, 8'h00);
    wr_reg(OFS_TEST_CTRL, 8'h13);
    rd_reg(OFS_TEST_CTRL, 8'h03);
    spec <= 1'b1;
    rd_reg(OFS_TEST_BITS, 8'h5A);
    xmask <= 1'b0;
    wr_reg(OFS_TEST_CTRL, 8'h17);
    rd_reg(OFS_TEST_CTRL, 8'h07);
    xmask <= 1'b1;
    wr_reg(OFS_TEST_CTRL, 8'h17);
    wr_reg(OFS_TEST_BITS, 8'hA5);
    rd_reg(OFS_TEST_BITS, 8'hA5);
    imask <= 1'b0;
    wr_reg(OFS_TEST_BITS, 8'h00);
    rd_reg(OFS_TEST_BITS, 8'hA5);
    vec_chk(16'hFF7E);
    imask <= 1'b1;
    wr_reg(OFS_TEST_CTRL, 8'h1F);
    wr_reg(OFS_TEST_BITS, 8'hFF);
    rd_reg(OFS_TEST_BITS, 8'h07);
    {imask, xmask} <= 2'b00;
    vec_chk(VEC_NONMASKABLE_PIN_REQUEST);
    check({15'h0000, late}, 16'h0000);
    stop_test();
  end
endmodule : interrupt_priority_vector_unit_bench
